// file: rtl/uhp_host_pins.sv
// Host bus pins and modem outputs of a FIFO UART
`timescale 1ns/1ps
`include "uhp_cfg.svh"
module uhp_host_pins (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  // Host pins
  input  wire uhp_pkg::uhp_pins_t i_pins,
  // Status and control from the UART core
  input  wire uhp_pkg::uhp_mcr_t  i_modem_ctl,
  input  wire logic              i_efr_auto_rts,
  input  wire uhp_pkg::uhp_core_t i_core,
  // Register access towards the core
  output logic                   o_reg_rd,
  output logic                   o_reg_wr,
  output logic [2:0]             o_reg_addr,
  // Host side outputs
  output logic                   o_drive_disable_or_printer2_decode,
  output uhp_pkg::uhp_tri_t      o_main_interrupt_out,
  output uhp_pkg::uhp_tri_t      o_irq_b_or_rx_ready,
  output uhp_pkg::uhp_tri_t      o_irq_c_or_tx_ready,
  output uhp_pkg::uhp_tri_t      o_port_select3_or_user_out2,
  // Modem outputs
  output logic                   o_rts_n,
  output logic                   o_dtr_n,
  output logic                   o_user_out1_n,
  output logic                   o_serial_en
);
  uhp_pkg::uhp_pins_t p_s;
  uhp_pkg::uhp_acc_t  acc_st_ff;
  uhp_pkg::uhp_acc_t  nxt_acc_st;
  logic       cs_lat_ff;
  logic [2:0] rsel_lat_ff;
  logic       rd_ff;
  logic       wr_ff;
  logic [2:0] addr_ff;
  logic       ddis_ff;
  logic       rts_flow_ff;
  logic       rts_n_ff;
  logic       dtr_n_ff;
  logic       op1_n_ff;
  logic       ser_en_ff;
  uhp_pkg::uhp_tri_t irq_a_ff;
  uhp_pkg::uhp_tri_t irq_b_ff;
  uhp_pkg::uhp_tri_t irq_c_ff;
  uhp_pkg::uhp_tri_t op2_ff;
  logic       com_hit;
  logic       lpt2_hit;

  // pins cross into the clock domain
  uhp_sync #(
    .W   ($bits(uhp_pkg::uhp_pins_t)),
    .RST (`UHP_PIN_IDLE)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       (i_pins),
    .o_q       (p_s)
  );

  // mode pin, pulled up for standard mode
  wire standard_bus_mode = (p_s.mode_sel == `UHP_MODE_STD);
  wire direct_a  = !standard_bus_mode;

  // dual read pin serves as address bit 3
  wire [6:0] pc_addr = {p_s.addr_hi, p_s.rd_hi};

  uhp_decode u_dec (
    .i_addr     (pc_addr),
    .i_aen_n    (p_s.as_n),
    .i_port_sel (p_s.port_sel[1:0]),
    .o_com_hit  (com_hit),
    .o_lpt2_hit (lpt2_hit)
  );

  // either read strobe is enough in standard mode
  wire rd_act = !p_s.rd_n || (standard_bus_mode && p_s.rd_hi);
  wire wr_act = !p_s.wr_n || (standard_bus_mode && p_s.wr_hi);

  // transparent while the strobe is low, held when high
  wire as_open  = standard_bus_mode && !p_s.as_n;
  wire cs_now   = as_open ? p_s.cs : cs_lat_ff;
  wire [2:0] rsel_now = as_open ? p_s.reg_sel : rsel_lat_ff;

  // Selection per mode
  wire sel      = standard_bus_mode ? cs_now : com_hit;
  wire [2:0] reg_addr = standard_bus_mode ? rsel_now : p_s.reg_sel;

  // Address latch; holds across the access
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cs_lat_ff   <= 1'b0;
      rsel_lat_ff <= 3'h0;
    end
    else if (as_open)
    begin
      cs_lat_ff   <= p_s.cs;
      rsel_lat_ff <= p_s.reg_sel;
    end
  end

  // read fires at strobe start, write at strobe end
  always_comb
  begin
    nxt_acc_st = acc_st_ff;
    case (acc_st_ff)
      uhp_pkg::ACC_IDLE:
        if (sel && rd_act)
          nxt_acc_st = uhp_pkg::ACC_RD;
        else if (sel && wr_act)
          nxt_acc_st = uhp_pkg::ACC_WR;
      uhp_pkg::ACC_RD:
        if (!rd_act)
          nxt_acc_st = uhp_pkg::ACC_IDLE;
      uhp_pkg::ACC_WR:
        if (!wr_act)
          nxt_acc_st = uhp_pkg::ACC_IDLE;
      default:
        nxt_acc_st = uhp_pkg::ACC_IDLE;
    endcase
  end

  wire nxt_rd = (acc_st_ff == uhp_pkg::ACC_IDLE) &&
                (nxt_acc_st == uhp_pkg::ACC_RD);
  wire nxt_wr = (acc_st_ff == uhp_pkg::ACC_WR) && !wr_act;
  // Capture the address once, at access start
  wire acc_start = (acc_st_ff == uhp_pkg::ACC_IDLE) &&
                   (nxt_acc_st != uhp_pkg::ACC_IDLE);

  // Access sequencer and pulses
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      acc_st_ff <= uhp_pkg::ACC_IDLE;
      rd_ff     <= 1'b0;
      wr_ff     <= 1'b0;
      addr_ff   <= 3'h0;
    end
    else
    begin
      acc_st_ff <= nxt_acc_st;
      rd_ff     <= nxt_rd;
      wr_ff     <= nxt_wr;
      if (acc_start)
        addr_ff <= reg_addr;
    end
  end

  // low while reading; printer decode in direct mode
  wire nxt_ddis = standard_bus_mode ? !(sel && rd_act) : !lpt2_hit;

  // flow state with hysteresis between two levels
  wire nxt_flow = i_core.rx_trig ? 1'b1 :
                  i_core.rx_low  ? 1'b0 : rts_flow_ff;
  // flow forces high only when enabled
  wire nxt_rts_n = !i_modem_ctl.rts ||
                   (i_efr_auto_rts && rts_flow_ff);

  // Interrupt routing; S3 and S2 pick the line in direct mode
  wire [1:0] route = p_s.port_sel[2:1];
  wire irq   = i_core.irq_pend;
  wire osrc  = i_modem_ctl.irq_osrc;
  // modem bit 3 enables the direct-mode lines
  wire pc_en = i_modem_ctl.out2;
  // open source drives only while asserted
  wire drv   = osrc ? irq : 1'b1;

  // One three-state line in direct mode
  function automatic uhp_pkg::uhp_tri_t pc_line(input logic hit);
    pc_line.out = irq;
    pc_line.oe  = pc_en && hit && drv;
  endfunction : pc_line

  uhp_pkg::uhp_tri_t nxt_a;
  uhp_pkg::uhp_tri_t nxt_b;
  uhp_pkg::uhp_tri_t nxt_c;
  uhp_pkg::uhp_tri_t nxt_op2;

  // ready pins become interrupts in direct mode
  always_comb
  begin
    if (direct_a)
    begin
      nxt_a = pc_line(route == `UHP_ROUTE_A || route == 2'h3);
      nxt_b = pc_line(route == `UHP_ROUTE_B);
      nxt_c = pc_line(route == `UHP_ROUTE_C);
    end
    else
    begin
      nxt_a = '{out: irq, oe: drv};
      nxt_b = '{out: !i_core.rx_full, oe: 1'b1};
      nxt_c = '{out: i_core.tx_full, oe: 1'b1};
    end
  end

  // pin is an input in direct mode
  assign nxt_op2 = '{out: !i_modem_ctl.out2, oe: standard_bus_mode};

  // Interrupt and user pins registered to stop decode glitches
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      irq_a_ff <= '{out: 1'b0, oe: 1'b0};
      irq_b_ff <= '{out: 1'b0, oe: 1'b0};
      irq_c_ff <= '{out: 1'b0, oe: 1'b0};
      op2_ff   <= '{out: `UHP_OUT_N_RST, oe: 1'b0};
    end
    else
    begin
      irq_a_ff <= nxt_a;
      irq_b_ff <= nxt_b;
      irq_c_ff <= nxt_c;
      op2_ff   <= nxt_op2;
    end
  end

  // modem outputs and serial enable from reset
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ddis_ff     <= 1'b1;
      rts_flow_ff <= 1'b0;
      rts_n_ff    <= `UHP_RTS_N_RST;
      dtr_n_ff    <= `UHP_DTR_N_RST;
      op1_n_ff    <= `UHP_OUT_N_RST;
      ser_en_ff   <= 1'b0;
    end
    else
    begin
      ddis_ff     <= nxt_ddis;
      rts_flow_ff <= nxt_flow;
      rts_n_ff    <= nxt_rts_n;
      dtr_n_ff    <= !i_modem_ctl.dtr;
      op1_n_ff    <= !i_modem_ctl.out1;
      ser_en_ff   <= 1'b1;
    end
  end

  // Output wiring
  assign o_reg_rd   = rd_ff;
  assign o_reg_wr   = wr_ff;
  assign o_reg_addr = addr_ff;
  assign o_drive_disable_or_printer2_decode = ddis_ff;
  assign o_main_interrupt_out = irq_a_ff;
  assign o_irq_b_or_rx_ready  = irq_b_ff;
  assign o_irq_c_or_tx_ready  = irq_c_ff;
  assign o_port_select3_or_user_out2 = op2_ff;
  assign o_rts_n       = rts_n_ff;
  assign o_dtr_n       = dtr_n_ff;
  assign o_user_out1_n = op1_n_ff;
  assign o_serial_en   = ser_en_ff;

  // Checks on the pin behaviour
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence rd_begin_s;
    acc_st_ff == uhp_pkg::ACC_IDLE && sel && rd_act;
  endsequence
  sequence rd_pulse_s;
    o_reg_rd ##1 !o_reg_rd;
  endsequence

  read_once_a: assert property (rd_begin_s |=> rd_pulse_s)
    else $error("read strobe did not give exactly one read");
  // high strobe alone reads in standard mode
  read_hi_a: assert property (standard_bus_mode && p_s.rd_hi &&
    p_s.rd_n && sel && acc_st_ff == uhp_pkg::ACC_IDLE |=> o_reg_rd)
    else $error("active high read strobe ignored");
  addr_latch_a: assert property (as_open |=>
    cs_lat_ff == $past(p_s.cs) && rsel_lat_ff == $past(p_s.reg_sel))
    else $error("address strobe did not latch chip select");
  // drive disable low during a read
  ddis_read_a: assert property (standard_bus_mode && sel && rd_act |=>
    !o_drive_disable_or_printer2_decode)
    else $error("drive disable not low during read");
  lpt2_dec_a: assert property (direct_a |=>
    o_drive_disable_or_printer2_decode == !$past(lpt2_hit))
    else $error("printer decode output wrong");
  ready_std_a: assert property (standard_bus_mode |=>
    o_irq_c_or_tx_ready.out == $past(i_core.tx_full) &&
    o_irq_b_or_rx_ready.out == !$past(i_core.rx_full))
    else $error("ready outputs do not follow FIFO state");
  // lines released when bit 3 clear
  pc_irq_off_a: assert property (direct_a && !pc_en |=>
    !o_main_interrupt_out.oe && !o_irq_b_or_rx_ready.oe &&
    !o_irq_c_or_tx_ready.oe)
    else $error("direct mode interrupt driven while disabled");
  irq_std_a: assert property (standard_bus_mode && !osrc |=>
    o_main_interrupt_out.oe &&
    o_main_interrupt_out.out == $past(irq))
    else $error("standard mode interrupt not driven");
  irq_osrc_a: assert property (osrc && !irq |=>
    !o_main_interrupt_out.oe)
    else $error("open source interrupt drove while idle");
  // auto flow forces request-to-send high while still enabled
  rts_auto_a: assert property (i_efr_auto_rts && i_core.rx_trig
    ##1 i_efr_auto_rts |=> o_rts_n)
    else $error("request-to-send not forced by flow control");
  rts_man_a: assert property (!i_efr_auto_rts && i_modem_ctl.rts
    |=> !o_rts_n)
    else $error("request-to-send not low when bit set");
  modem_out_a: assert property (1'b1 |=>
    o_dtr_n == !$past(i_modem_ctl.dtr) &&
    o_user_out1_n == !$past(i_modem_ctl.out1))
    else $error("modem outputs do not follow control bits");
  // general purpose output in standard mode only
  op2_a: assert property (1'b1 |=>
    o_port_select3_or_user_out2.oe == $past(standard_bus_mode))
    else $error("select-3 pin direction wrong for mode");
endmodule : uhp_host_pins

// file: rtl/uhp_cfg.svh
// Constants for the UART host pin block
`ifndef UHP_CFG_SVH
`define UHP_CFG_SVH
// Port bases as address bits 9..3
`define UHP_COM1_BASE 7'h7F
`define UHP_COM2_BASE 7'h5F
`define UHP_COM3_BASE 7'h7D
`define UHP_COM4_BASE 7'h5D
`define UHP_LPT2_BASE 7'h4F
// Pin levels seen by the synchroniser while reset is held
`define UHP_PIN_IDLE 19'h54200
// Mode select level for the standard bus mode
`define UHP_MODE_STD 1'b1
// Interrupt line route codes in direct mode
`define UHP_ROUTE_A 2'h0
`define UHP_ROUTE_B 2'h1
`define UHP_ROUTE_C 2'h2
// Reset levels of the modem outputs
`define UHP_RTS_N_RST 1'b1
`define UHP_DTR_N_RST 1'b1
`define UHP_OUT_N_RST 1'b1
`endif

// file: rtl/uhp_pkg.sv
// Types shared by the UART host pin block
package uhp_pkg;
  // Host pins, in synchroniser bit order
  typedef struct packed {
    logic       rd_n;
    logic       rd_hi;
    logic       wr_n;
    logic       wr_hi;
    logic       as_n;
    logic [2:0] reg_sel;
    logic       cs;
    logic       mode_sel;
    logic [5:0] addr_hi;
    logic [2:0] port_sel;
  } uhp_pins_t;
  // Modem control register image
  typedef struct packed {
    logic [1:0] rsvd;
    logic       irq_osrc;
    logic       loop;
    logic       out2;
    logic       out1;
    logic       rts;
    logic       dtr;
  } uhp_mcr_t;
  // Status from the UART core
  typedef struct packed {
    logic tx_full;
    logic rx_full;
    logic rx_trig;
    logic rx_low;
    logic irq_pend;
  } uhp_core_t;
  // A three-state or open-source pin
  typedef struct packed {
    logic out;
    logic oe;
  } uhp_tri_t;
  // Host access sequencer
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_RD,
    ACC_WR
  } uhp_acc_t;
endpackage : uhp_pkg

// file: rtl/uhp_sync.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module uhp_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_sys_rst,
  // Pins in, synchronised out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  // First stage feeds only the second
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta_ff <= RST;
      q_ff    <= RST;
    end
    else
    begin
      meta_ff <= i_d;
      q_ff    <= meta_ff;
    end
  end
  assign o_q = q_ff;
endmodule : uhp_sync

// file: rtl/uhp_decode.sv
// Serial and printer port address decoder for direct mode
`timescale 1ns/1ps
`include "uhp_cfg.svh"
module uhp_decode (
  // Address bits 9..3 and enable
  input  wire logic [6:0] i_addr,
  input  wire logic       i_aen_n,
  // Port choice
  input  wire logic [1:0] i_port_sel,
  // Decode results
  output logic            o_com_hit,
  output logic            o_lpt2_hit
);
  // Match an eight-byte block base
  function automatic logic is_base(input logic [6:0] a,
                                   input logic [6:0] b);
    is_base = (a == b);
  endfunction : is_base

  wire com1 = is_base(i_addr, `UHP_COM1_BASE);
  wire com2 = is_base(i_addr, `UHP_COM2_BASE);
  wire com3 = is_base(i_addr, `UHP_COM3_BASE);
  wire com4 = is_base(i_addr, `UHP_COM4_BASE);
  wire [3:0] com_vec = {com4, com3, com2, com1};

  assign o_com_hit  = !i_aen_n && com_vec[i_port_sel];
  assign o_lpt2_hit = !i_aen_n && is_base(i_addr, `UHP_LPT2_BASE);
endmodule : uhp_decode

// file: testbench/uhp_host_model.sv
// Host CPU model that drives the bus pins of the UART host pin block
`timescale 1ns/1ps
`include "uhp_cfg.svh"
module uhp_host_model (
  // Clock
  input  wire logic          i_sys_clk,
  // Host pins
  output uhp_pkg::uhp_pins_t o_pins
);
  // Idle bus at time zero: strobes off, standard mode
  initial o_pins = `UHP_PIN_IDLE;

  // Change address and mode pins, then give the synchroniser time
  task automatic set_pins(input uhp_pkg::uhp_pins_t p);
    @(negedge i_sys_clk);
    o_pins = p;
    repeat (4) @(negedge i_sys_clk);
  endtask : set_pins

  // Raise or drop one strobe; the other pins keep their levels
  task automatic strobe(input logic wr, input logic hi, input logic on);
    @(negedge i_sys_clk);
    if (wr && hi) o_pins.wr_hi = on;
    if (wr && !hi) o_pins.wr_n = !on;
    if (!wr && hi) o_pins.rd_hi = on;
    if (!wr && !hi) o_pins.rd_n = !on;
  endtask : strobe
endmodule : uhp_host_model

// file: testbench/uart_host_pin_interface_tb.sv
// Self-checking bench for the UART host pin block
`timescale 1ns/1ps
module uart_host_pin_interface_tb;
  // Clock, reset and stimulus
  logic               i_sys_clk;
  logic               i_sys_rst;
  uhp_pkg::uhp_pins_t pins;
  uhp_pkg::uhp_pins_t cfg;
  uhp_pkg::uhp_mcr_t  modem_control_reg;
  logic               auto_rts;
  uhp_pkg::uhp_core_t core;
  // Design outputs
  logic               reg_rd;
  logic               reg_wr;
  logic [2:0]         reg_addr;
  logic               ddis;
  uhp_pkg::uhp_tri_t  irq_a;
  uhp_pkg::uhp_tri_t  irq_b;
  uhp_pkg::uhp_tri_t  irq_c;
  uhp_pkg::uhp_tri_t  op2;
  logic               rts_n;
  logic               dtr_n;
  logic               out1_n;
  logic               ser_en;
  // Scoreboard of expected accesses {wr, rd, addr}
  logic [7:0]         exp_q[$];
  int                 mismatches;
  int                 num_checks;
  logic [31:0]        rnd;
  logic [3:0]         oe_exp;
  localparam logic [5:0] COM_HI [4] = '{6'h3F, 6'h2F, 6'h3E, 6'h2E};

  // Free-running 200 MHz clock
  initial i_sys_clk = 1'b0;
  always #2.5 i_sys_clk = ~i_sys_clk;

  uhp_host_model host_u (
    .i_sys_clk (i_sys_clk),
    .o_pins    (pins)
  );

  uhp_host_pins dut_u (
    .i_sys_clk                          (i_sys_clk),
    .i_sys_rst                          (i_sys_rst),
    .i_pins                             (pins),
    .i_modem_ctl                        (modem_control_reg),
    .i_efr_auto_rts                     (auto_rts),
    .i_core                             (core),
    .o_reg_rd                           (reg_rd),
    .o_reg_wr                           (reg_wr),
    .o_reg_addr                         (reg_addr),
    .o_drive_disable_or_printer2_decode (ddis),
    .o_main_interrupt_out               (irq_a),
    .o_irq_b_or_rx_ready                (irq_b),
    .o_irq_c_or_tx_ready                (irq_c),
    .o_port_select3_or_user_out2        (op2),
    .o_rts_n                            (rts_n),
    .o_dtr_n                            (dtr_n),
    .o_user_out1_n                      (out1_n),
    .o_serial_en                        (ser_en)
  );

  // Compare and count; an unknown bit matches only an unknown bit
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic wrap_up;
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // Let registered outputs follow new levels
  task automatic settle;
    repeat (4) @(negedge i_sys_clk);
  endtask : settle

  // One strobe; note the access first if it should be taken
  task automatic access(input logic wr, input logic hi, input logic take,
                        input logic std, input logic [2:0] addr);
    if (take)
      exp_q.push_back({3'h0, wr, !wr, addr});
    rnd = $urandom;
    host_u.strobe(wr, hi, 1'b1);
    repeat (4 + rnd[1:0]) @(negedge i_sys_clk);
    if (std && !wr) check("ddis_read", ddis, !take);
    host_u.strobe(wr, hi, 1'b0);
    repeat (6) @(negedge i_sys_clk);
    if (std) check("ddis_idle", ddis, 1'b1);
  endtask : access

  // Monitor: every pulse must match the oldest note, one cycle wide
  always @(negedge i_sys_clk)
    if (!i_sys_rst && (reg_rd === 1'b1 || reg_wr === 1'b1))
    begin
      if (exp_q.size() == 0)
        check("stray_access", {3'h0, reg_wr, reg_rd, reg_addr}, 8'hFF);
      else
        check("access", {3'h0, reg_wr, reg_rd, reg_addr},
              exp_q.pop_front());
    end

  // Hang guard: a bounded run, then the verdict
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    mismatches = 0;
    num_checks = 0;
    i_sys_rst = 1'b1;
    modem_control_reg = 8'h00;
    auto_rts = 1'b0;
    core = 5'h00;
    rnd = $urandom(22629);
    repeat (2) @(negedge i_sys_clk);
    check("rst_levels", {ser_en, rts_n, dtr_n, out1_n, ddis, reg_rd, reg_wr},
          8'h3C);
    i_sys_rst = 1'b0;
    settle();
    check("serial_en", ser_en, 1'b1);
    // Standard mode, all registers, all four strobe kinds
    cfg = pins;
    cfg.as_n = 1'b0;
    cfg.cs = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      cfg.reg_sel = i[2:0];
      host_u.set_pins(cfg);
      access(i[1], i[0], 1'b1, 1'b1, cfg.reg_sel);
    end
    // Not selected: no access, no drive disable
    cfg.cs = 1'b0;
    host_u.set_pins(cfg);
    access(1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
    // Address strobe holds selects once it rises
    cfg.cs = 1'b1;
    cfg.reg_sel = 3'h5;
    host_u.set_pins(cfg);
    cfg.as_n = 1'b1;
    host_u.set_pins(cfg);
    cfg.reg_sel = 3'h2;
    cfg.cs = 1'b0;
    host_u.set_pins(cfg);
    access(1'b0, 1'b0, 1'b1, 1'b1, 3'h5);
    access(1'b1, 1'b0, 1'b1, 1'b1, 3'h5);
    // Random modem control and core status in standard mode
    for (int i = 0; i < 12; i++)
    begin
      rnd = $urandom;
      modem_control_reg = rnd[7:0];
      core = rnd[12:8];
      settle();
      check("rts_n", rts_n, !modem_control_reg.rts);
      check("dtr_n", dtr_n, !modem_control_reg.dtr);
      check("out1_n", out1_n, !modem_control_reg.out1);
      check("op2", op2, {!modem_control_reg.out2, 1'b1});
      check("tx_ready", irq_c, {core.tx_full, 1'b1});
      check("rx_ready", irq_b, {!core.rx_full, 1'b1});
      if (modem_control_reg.irq_osrc)
        check("irq_osrc", irq_a.oe, core.irq_pend);
      else
        check("irq_std", irq_a, {core.irq_pend, 1'b1});
    end
    // Automatic request-to-send hysteresis
    modem_control_reg = 8'h02;
    core = 5'h04;
    settle();
    check("rts_manual", rts_n, 1'b0);
    core = 5'h02;
    auto_rts = 1'b1;
    settle();
    check("rts_below", rts_n, 1'b0);
    core = 5'h04;
    settle();
    check("rts_trig", rts_n, 1'b1);
    core = 5'h00;
    settle();
    check("rts_between", rts_n, 1'b1);
    core = 5'h02;
    settle();
    check("rts_restored", rts_n, 1'b0);
    auto_rts = 1'b0;
    // Direct mode: mode first, then address bit 3 high
    cfg.mode_sel = 1'b0;
    host_u.set_pins(cfg);
    check("op2_input", op2.oe, 1'b0);
    cfg.as_n = 1'b0;
    cfg.rd_hi = 1'b1;
    cfg.reg_sel = 3'h3;
    for (int p = 0; p < 4; p++)
    begin
      cfg.port_sel = {1'b0, p[1:0]};
      cfg.addr_hi = COM_HI[p];
      host_u.set_pins(cfg);
      access(1'b0, 1'b0, 1'b1, 1'b0, 3'h3);
      access(1'b1, 1'b0, 1'b1, 1'b0, 3'h3);
    end
    cfg.port_sel = 3'h0;
    cfg.addr_hi = COM_HI[0];
    cfg.as_n = 1'b1;
    host_u.set_pins(cfg);
    access(1'b0, 1'b0, 1'b0, 1'b0, 3'h3);
    cfg.as_n = 1'b0;
    cfg.rd_hi = 1'b0;
    host_u.set_pins(cfg);
    access(1'b0, 1'b0, 1'b0, 1'b0, 3'h3);
    // Printer port two decode on the drive disable pin
    cfg.addr_hi = 6'h27;
    cfg.rd_hi = 1'b1;
    host_u.set_pins(cfg);
    check("lpt2_hit", ddis, 1'b0);
    cfg.addr_hi = 6'h3F;
    host_u.set_pins(cfg);
    check("lpt2_miss", ddis, 1'b1);
    // Interrupt routing; each route drives one line (route 3 shares line A) while modem bit 3 is set
    modem_control_reg = 8'h08;
    core = 5'h01;
    for (int r = 0; r < 4; r++)
    begin
      cfg.port_sel = {r[1:0], 1'b0};
      host_u.set_pins(cfg);
      oe_exp = (r == 1) ? 4'h4 : (r == 2) ? 4'h2 : 4'h8;
      check("irq_oe", {irq_a.oe, irq_b.oe, irq_c.oe, op2.oe}, oe_exp);
      check("irq_out", {irq_a.out & irq_a.oe, irq_b.out & irq_b.oe,
            irq_c.out & irq_c.oe, 1'b0}, oe_exp);
    end
    // Open-source line in direct mode: released while no interrupt
    modem_control_reg = 8'h28;
    core = 5'h00;
    settle();
    check("irq_osrc_idle", irq_a.oe, 1'b0);
    core = 5'h01;
    settle();
    check("irq_osrc_busy", irq_a, 8'h3);
    modem_control_reg = 8'h00;
    settle();
    check("irq_off", {irq_a.oe, irq_b.oe, irq_c.oe}, 8'h0);
    repeat (8) @(negedge i_sys_clk);
    check("notes_left", 8'(exp_q.size()), 8'h0);
    wrap_up();
  end
endmodule : uart_host_pin_interface_tb
